// [bench/rxo_host_model.sv]
// host model issuing register writes and reads
module rxo_host_model (
	// clock
	input wire logic       core_clk,
	// register access
	output logic     [7:0] reg_addr,
	output logic           reg_wr,
	output logic     [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	// bus idle from time zero; the bench never drives these itself
	initial
	begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wr    <= 1'b1;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		// released data shows no stale value
		reg_wdata <= ~d;
	endtask : wr
	// read data is combinational, taken once settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
endmodule : rxo_host_model

// [bench/rxo_regs_asserts.sv]
// concurrent checks on the receiver override register bank ports
module rxo_regs_asserts (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	// internal state
	input wire logic [2:0] power_state,
	input wire logic       fsm_buf_en,
	input wire logic       idle_mode,
	input wire logic [6:0] cal_coarse_result,
	input wire logic [6:0] cal_fine_result,
	input wire logic [3:0] cal_adc_tune,
	input wire logic       fsm_xtal_en,
	// controls
	input wire logic       xtal_buf_en,
	input wire logic [6:0] rc_coarse_trim,
	input wire logic [6:0] rc_fine_trim,
	input wire logic       dig_domain_on,
	input wire logic       xtal_en,
	input wire logic [3:0] adc_tune
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// address matches; read data is live, so it mirrors the stored fields
	wire a61 = reg_addr == rxo_pkg::ADDR_COEF_VALUE;
	wire a62 = reg_addr == rxo_pkg::ADDR_XTAL_CTRL;
	wire a63 = reg_addr == rxo_pkg::ADDR_RC_COARSE;
	wire a64 = reg_addr == rxo_pkg::ADDR_RC_FINE;
	wire a65 = reg_addr == rxo_pkg::ADDR_REG_OVR;
	wire a66 = reg_addr == rxo_pkg::ADDR_REG_LEVEL;
	wire a67 = reg_addr == rxo_pkg::ADDR_ADC_TUNE;

	pwst_view_a: assert property (a62 |-> reg_rdata[7:5] == power_state)
		else $error("power state field differs from live state");
	buf_fsm_a: assert property (a62 && !reg_rdata[1] |=> xtal_buf_en == $past(fsm_buf_en))
		else $error("buffer enable not from state machine");
	buf_ovr_a: assert property (a62 && reg_rdata[1] |=> xtal_buf_en == $past(reg_rdata[0]))
		else $error("buffer enable not from enable bit");
	coarse_view_a: assert property (a63 && !reg_rdata[7] |-> reg_rdata[6:0] == cal_coarse_result)
		else $error("coarse read not internal result");
	coarse_trim_a: assert property (a63 |=> rc_coarse_trim == $past(reg_rdata[6:0]))
		else $error("coarse trim differs from field");
	fine_view_a: assert property (a64 && !reg_rdata[7] |-> reg_rdata[6:0] == cal_fine_result)
		else $error("fine read not internal result");
	fine_trim_a: assert property (a64 |=> rc_fine_trim == $past(reg_rdata[6:0]))
		else $error("fine trim differs from field");
	dig_pwdn_a: assert property (a65 |=> dig_domain_on == !($past(reg_rdata[0]) && $past(idle_mode)))
		else $error("digital domain power wrong");
	glob_ovr_a: assert property (a66 |=> xtal_en ==
		($past(reg_rdata[7]) ? $past(reg_rdata[6])
		: ($past(reg_rdata[6]) | $past(fsm_xtal_en))))
		else $error("xtal enable qualifier wrong");
	adc_ovr_a: assert property (a67 |=> adc_tune ==
		($past(reg_rdata[4]) ? $past(reg_rdata[3:0]) : $past(cal_adc_tune)))
		else $error("adc tune source wrong");
	coef_rsvd_a: assert property (a61 |-> reg_rdata[7:6] == 2'h0)
		else $error("reserved coefficient bits not zero");
endmodule : rxo_regs_asserts

bind rxo_regs rxo_regs_asserts rxo_regs_asserts_inst (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .power_state(power_state),
	.fsm_buf_en(fsm_buf_en), .idle_mode(idle_mode), .cal_coarse_result(cal_coarse_result),
	.cal_fine_result(cal_fine_result), .cal_adc_tune(cal_adc_tune), .fsm_xtal_en(fsm_xtal_en),
	.xtal_buf_en(xtal_buf_en), .rc_coarse_trim(rc_coarse_trim), .rc_fine_trim(rc_fine_trim),
	.dig_domain_on(dig_domain_on), .xtal_en(xtal_en), .adc_tune(adc_tune));

// [bench/tb.sv]
// self-checking bench for the receiver override register bank
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       core_clk, rst, fsm_buf_en, idle_mode, fsm_xtal_en, reg_wr;
	logic       fsm_bias_en, fsm_ts_en, fsm_rc32_en, clk_hyst, double_bias, bias_en;
	logic       ts_en, rc32_en, adc_reset, adc_refdac_en, adc_en;
	logic [4:0] ldo_en;
	logic [2:0] dig_ldo_level;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [2:0] power_state;
	logic [6:0] cal_coarse_result, cal_fine_result, rc_coarse_trim, rc_fine_trim;
	logic [3:0] cal_adc_tune, path_coef_addr, adc_tune;
	logic [5:0] path_coef_data;
	logic       xtal_buf_en, double_amplification, smart_por_en, dig_domain_on, xtal_en;
	int         err_total, n_checks, cyc;
	logic [2:0] pw [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	logic [7:0] bd [4] = '{8'h05, 8'h07, 8'h06, 8'h05};
	logic       bf [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic       be [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

	rxo_regs rxo_regs_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.power_state(power_state), .fsm_buf_en(fsm_buf_en), .idle_mode(idle_mode),
		.cal_coarse_result(cal_coarse_result), .cal_fine_result(cal_fine_result),
		.cal_adc_tune(cal_adc_tune), .fsm_bias_en(fsm_bias_en), .fsm_xtal_en(fsm_xtal_en),
		.fsm_ts_en(fsm_ts_en), .fsm_rc32_en(fsm_rc32_en), .path_coef_addr(path_coef_addr),
		.path_coef_data(path_coef_data), .xtal_buf_en(xtal_buf_en), .clk_hyst(clk_hyst),
		.double_bias(double_bias), .double_amplification(double_amplification),
		.rc_coarse_trim(rc_coarse_trim), .rc_fine_trim(rc_fine_trim),
		.smart_por_en(smart_por_en), .bias_en(bias_en), .ldo_en(ldo_en),
		.dig_domain_on(dig_domain_on), .xtal_en(xtal_en), .ts_en(ts_en), .rc32_en(rc32_en),
		.dig_ldo_level(dig_ldo_level), .adc_reset(adc_reset), .adc_refdac_en(adc_refdac_en),
		.adc_en(adc_en), .adc_tune(adc_tune));
	rxo_host_model rxo_host_model_inst (.core_clk(core_clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// free running clock
	always #2.5 core_clk = ~core_clk;

	task automatic wrap_up();
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// hang guard, far above the expected run length
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rxo_host_model_inst.wr(a, d);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		rxo_host_model_inst.rd(a, rv);
		chk(what, rv, exp);
	endtask : rchk
	// outputs trail the register by one edge
	task automatic w3();
		repeat (3) @(negedge core_clk);
	endtask : w3

	task automatic t_reset();
		rchk(8'h60, 8'h00, "coef addr");
		rchk(8'h61, 8'h00, "coef value");
		rchk(8'h62, {power_state, 5'h04}, "xtal ctrl");
		rchk(8'h63, {1'b0, cal_coarse_result}, "coarse");
		rchk(8'h65, 8'h81, "ldo ovr");
		chk("amp2x", {7'h0, double_amplification}, 8'h01);
		chk("spor", {7'h0, smart_por_en}, 8'h01);
		chk("adc tune", {4'h0, adc_tune}, 8'h0D);
	endtask : t_reset

	task automatic t_coef();
		wr(8'h60, 8'h05);
		wr(8'h61, 8'h2A);
		wr(8'h60, 8'hF3);
		wr(8'h61, 8'hD5);
		rchk(8'h60, 8'h03, "addr field");
		rchk(8'h61, 8'h15, "entry 3");
		@(posedge core_clk);
		path_coef_addr <= 4'h3;
		wr(8'h60, 8'h05);
		rchk(8'h61, 8'h2A, "entry 5");
		chk("path", {2'h0, path_coef_data}, 8'h15);
	endtask : t_coef

	task automatic t_xtal();
		foreach (pw[i])
		begin
			@(posedge core_clk);
			power_state <= pw[i];
			rchk(8'h62, {pw[i], 5'h04}, "pwst");
		end
		foreach (bd[i])
		begin
			@(posedge core_clk);
			fsm_buf_en <= bf[i];
			wr(8'h62, bd[i]);
			w3();
			chk("buf en", {7'h0, xtal_buf_en}, {7'h0, be[i]});
		end
	endtask : t_xtal

	task automatic t_cal();
		@(posedge core_clk);
		cal_coarse_result <= 7'h55;
		cal_fine_result   <= 7'h2B;
		rchk(8'h64, 8'h2B, "fine view");
		wr(8'h63, 8'h85);
		wr(8'h64, 8'hFE);
		rchk(8'h63, 8'h85, "coarse ovr");
		w3();
		chk("coarse trim", {1'b0, rc_coarse_trim}, 8'h05);
		chk("fine trim", {1'b0, rc_fine_trim}, 8'h7E);
		wr(8'h63, 8'h00);
		w3();
		chk("coarse back", {1'b0, rc_coarse_trim}, 8'h55);
	endtask : t_cal

	task automatic t_misc();
		@(posedge core_clk);
		fsm_xtal_en <= 1'b1;
		idle_mode   <= 1'b1;
		cal_adc_tune <= 4'h6;
		wr(8'h66, 8'h08);
		w3();
		chk("xtal on", {7'h0, xtal_en}, 8'h01);
		chk("dig off", {7'h0, dig_domain_on}, 8'h00);
		wr(8'h66, 8'h88);
		wr(8'h65, 8'h80);
		wr(8'h67, 8'h03);
		rchk(8'h66, 8'h80, "level rsvd");
		w3();
		chk("xtal off", {7'h0, xtal_en}, 8'h00);
		chk("dig on", {7'h0, dig_domain_on}, 8'h01);
		chk("adc int", {4'h0, adc_tune}, 8'h06);
		wr(8'h70, 8'hFF);
		rchk(8'h70, 8'h00, "unmapped");
	endtask : t_misc

	// remaining control outputs, qualifier low then high
	task automatic t_outs();
		@(posedge core_clk);
		fsm_bias_en <= 1'b1;
		fsm_ts_en   <= 1'b1;
		fsm_rc32_en <= 1'b0;
		wr(8'h62, 8'h1C);
		wr(8'h65, 8'h3E);
		wr(8'h66, 8'h03);
		wr(8'h67, 8'hE0);
		w3();
		chk("xtal bits", {5'h0, clk_hyst, double_bias, double_amplification}, 8'h07);
		chk("ldo bits", {smart_por_en, bias_en, ldo_en, dig_domain_on}, 8'h7F);
		chk("level low", {ts_en, rc32_en, 3'h0, dig_ldo_level}, 8'h83);
		chk("adc bits", {adc_reset, adc_refdac_en, adc_en, 1'b0, adc_tune}, 8'hE6);
		wr(8'h66, 8'hB5);
		w3();
		chk("level high", {bias_en, ts_en, rc32_en, 2'h0, dig_ldo_level}, 8'h65);
	endtask : t_outs

	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		power_state = 3'h1;
		{fsm_buf_en, idle_mode, fsm_xtal_en} = 3'h0;
		cal_coarse_result = 7'h11;
		cal_fine_result = 7'h22;
		cal_adc_tune = 4'h0;
		path_coef_addr = 4'h0;
		{fsm_bias_en, fsm_ts_en, fsm_rc32_en} = 3'h0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_coef();
		t_xtal();
		t_cal();
		t_misc();
		t_outs();
		wrap_up();
	end
endmodule : tb

// [design/rxo_coef_table.sv]
// channel filter coefficient table with one selected entry port
module rxo_coef_table #(
	parameter int ADDR_W  = rxo_pkg::COEF_ADDR_W,
	parameter int VAL_W   = rxo_pkg::COEF_VAL_W,
	parameter int ENTRIES = rxo_pkg::COEF_ENTRIES
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// host side selected entry
	input  wire logic [ADDR_W-1:0] sel_addr,
	input  wire logic              wr_en,
	input  wire logic [VAL_W-1:0]  wr_data,
	output logic      [VAL_W-1:0]  rd_data,
	// receive path lookup
	input  wire logic [ADDR_W-1:0] path_addr,
	output logic      [VAL_W-1:0]  path_data
);
	logic [VAL_W-1:0] entry [ENTRIES];

	// per-entry storage, all zero after reset
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_entry
			always_ff @(posedge core_clk)
			begin
				if (rst)
					entry[g] <= '0;
				else if (wr_en && sel_addr == ADDR_W'(g))
					entry[g] <= wr_data;
			end
		end
	endgenerate

	assign rd_data   = entry[sel_addr];
	assign path_data = entry[path_addr];
endmodule : rxo_coef_table

// [design/rxo_pkg.sv]
// constants for the receiver test and override register bank
// Notes on behaviour
// - The coefficient value field reads and writes the filter table entry picked by the address.
// - A four-bit coefficient address in the low nibble of register 0x60 picks the table entry.
// - A read-only three-bit power state sits in the top bits: 000 low, 001 ready, 011 tune, 111 rx.
// - Buffer override 0 lets the state machine drive the buffer enable; 1 lets the enable bit drive it.
// - The buffer enable bit has no effect while the buffer override bit is clear.
// - With coarse override clear, the coarse field reads the internal coarse calibration result.
// - With coarse override set, the written coarse value replaces the internal result.
// - With fine override clear, the fine field reads the internal fine calibration result.
// - With fine override set, the written fine value replaces the internal result.
// - Global override high drives override bits both ways; low lets them only force blocks on.
// - Regulator override resets to 0x81: smart reset and idle powerdown on, all enables off.
// - Digital powerdown enable powers the digital domain down while idle; clear keeps it up.
// - Oscillator control writable bits reset to 00100, only double amplification set.
// - Coefficient value and coarse calibration registers reset to zero.
// - ADC tune override set selects the host-written four-bit tune over the internal value.
package rxo_pkg;
	localparam logic [7:0] ADDR_COEF_ADDR  = 8'h60;
	localparam logic [7:0] ADDR_COEF_VALUE = 8'h61;
	localparam logic [7:0] ADDR_XTAL_CTRL  = 8'h62;
	localparam logic [7:0] ADDR_RC_COARSE  = 8'h63;
	localparam logic [7:0] ADDR_RC_FINE    = 8'h64;
	localparam logic [7:0] ADDR_REG_OVR    = 8'h65;
	localparam logic [7:0] ADDR_REG_LEVEL  = 8'h66;
	localparam logic [7:0] ADDR_ADC_TUNE   = 8'h67;

	localparam logic [7:0] RST_COEF_ADDR   = 8'h00;
	localparam logic [7:0] RST_COEF_VALUE  = 8'h00;
	localparam logic [4:0] RST_XTAL_CTRL   = 5'h04;
	localparam logic [7:0] RST_RC_COARSE   = 8'h00;
	localparam logic [7:0] RST_RC_FINE     = 8'h00;
	localparam logic [7:0] RST_REG_OVR     = 8'h81;
	localparam logic [7:0] RST_REG_LEVEL   = 8'h00;
	localparam logic [7:0] RST_ADC_TUNE    = 8'h1D;

	// table shape
	localparam int COEF_ADDR_W  = 4;
	localparam int COEF_VAL_W   = 6;
	localparam int COEF_ENTRIES = 16;

	// field positions
	localparam int XTAL_PWST_LSB  = 5;
	localparam int XTAL_HYST_BIT  = 4;
	localparam int XTAL_BIAS_BIT  = 3;
	localparam int XTAL_AMP_BIT   = 2;
	localparam int XTAL_BUFOV_BIT = 1;
	localparam int XTAL_BUFEN_BIT = 0;
	localparam int CAL_OVR_BIT    = 7;
	localparam int OVR_SPOR_BIT   = 7;
	localparam int OVR_BIAS_BIT   = 6;
	localparam int OVR_DPWD_BIT   = 0;
	localparam int LVL_ENOVR_BIT  = 7;
	localparam int LVL_XTAL_BIT   = 6;
	localparam int LVL_TS_BIT     = 5;
	localparam int LVL_RC32_BIT   = 4;
	localparam int ADC_RST_BIT    = 7;
	localparam int ADC_REFDAC_BIT = 6;
	localparam int ADC_EN_BIT     = 5;
	localparam int ADC_OVR_BIT    = 4;

	// power state codes
	localparam logic [2:0] PWST_LOW_POWER = 3'h0;
	localparam logic [2:0] PWST_READY     = 3'h1;
	localparam logic [2:0] PWST_TUNE      = 3'h3;
	localparam logic [2:0] PWST_RECEIVE   = 3'h7;
endpackage : rxo_pkg

// [design/rxo_regs.sv]
// receiver test and override register bank
module rxo_regs #(
	parameter int ADDR_W = rxo_pkg::COEF_ADDR_W,
	parameter int VAL_W  = rxo_pkg::COEF_VAL_W
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// register access from the serial port decoder
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	// internal device state
	input  wire logic [2:0]        power_state,
	input  wire logic              fsm_buf_en,
	input  wire logic              idle_mode,
	input  wire logic [6:0]        cal_coarse_result,
	input  wire logic [6:0]        cal_fine_result,
	input  wire logic [3:0]        cal_adc_tune,
	input  wire logic              fsm_bias_en,
	input  wire logic              fsm_xtal_en,
	input  wire logic              fsm_ts_en,
	input  wire logic              fsm_rc32_en,
	// receive path coefficient lookup
	input  wire logic [ADDR_W-1:0] path_coef_addr,
	output logic      [VAL_W-1:0]  path_coef_data,
	// controls to analogue blocks
	output logic                   xtal_buf_en,
	output logic                   clk_hyst,
	output logic                   double_bias,
	output logic                   double_amplification,
	output logic      [6:0]        rc_coarse_trim,
	output logic      [6:0]        rc_fine_trim,
	output logic                   smart_por_en,
	output logic                   bias_en,
	output logic      [4:0]        ldo_en,
	output logic                   dig_domain_on,
	output logic                   xtal_en,
	output logic                   ts_en,
	output logic                   rc32_en,
	output logic      [2:0]        dig_ldo_level,
	output logic                   adc_reset,
	output logic                   adc_refdac_en,
	output logic                   adc_en,
	output logic      [3:0]        adc_tune
);
	// stored registers
	logic [7:0] coef_addr;
	logic [4:0] xtal_ctrl;
	logic [7:0] rc_coarse;
	logic [7:0] rc_fine;
	logic [7:0] reg_ovr;
	logic [7:0] reg_level;
	logic [7:0] adc_tuning_one;

	// write strobes
	wire wr_coef_addr = reg_wr && reg_addr == rxo_pkg::ADDR_COEF_ADDR;
	wire wr_coef_val  = reg_wr && reg_addr == rxo_pkg::ADDR_COEF_VALUE;
	wire wr_xtal      = reg_wr && reg_addr == rxo_pkg::ADDR_XTAL_CTRL;
	wire wr_coarse    = reg_wr && reg_addr == rxo_pkg::ADDR_RC_COARSE;
	wire wr_fine      = reg_wr && reg_addr == rxo_pkg::ADDR_RC_FINE;
	wire wr_ovr       = reg_wr && reg_addr == rxo_pkg::ADDR_REG_OVR;
	wire wr_level     = reg_wr && reg_addr == rxo_pkg::ADDR_REG_LEVEL;
	wire wr_adc       = reg_wr && reg_addr == rxo_pkg::ADDR_ADC_TUNE;

	// override selects
	wire coarse_ovr = rc_coarse[rxo_pkg::CAL_OVR_BIT];
	wire fine_ovr   = rc_fine[rxo_pkg::CAL_OVR_BIT];
	wire buf_ovr    = xtal_ctrl[rxo_pkg::XTAL_BUFOV_BIT];
	wire global_ovr = reg_level[rxo_pkg::LVL_ENOVR_BIT];
	wire adc_ovr    = adc_tuning_one[rxo_pkg::ADC_OVR_BIT];

	wire [VAL_W-1:0] coef_rd;

	// coefficient table behind the address/value pair
	rxo_coef_table #(
		.ADDR_W  (ADDR_W),
		.VAL_W   (VAL_W),
		.ENTRIES (rxo_pkg::COEF_ENTRIES)
	) u_table (
		.core_clk  (core_clk),
		.rst       (rst),
		.sel_addr  (coef_addr[ADDR_W-1:0]),
		.wr_en     (wr_coef_val),
		.wr_data   (reg_wdata[VAL_W-1:0]),
		.rd_data   (coef_rd),
		.path_addr (path_coef_addr),
		.path_data (path_coef_data)
	);

	// address register; upper nibble reserved, never stored
	always_ff @(posedge core_clk)
	begin
		if (rst)
			coef_addr <= rxo_pkg::RST_COEF_ADDR;
		else if (wr_coef_addr)
			coef_addr <= {4'h0, reg_wdata[3:0]};
	end

	// oscillator control; power state is live, not stored
	always_ff @(posedge core_clk)
	begin
		if (rst)
			xtal_ctrl <= rxo_pkg::RST_XTAL_CTRL;
		else if (wr_xtal)
			xtal_ctrl <= reg_wdata[4:0];
	end

	// calibration override registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rc_coarse <= rxo_pkg::RST_RC_COARSE;
			rc_fine   <= rxo_pkg::RST_RC_FINE;
		end
		else
		begin
			if (wr_coarse)
				rc_coarse <= reg_wdata;
			if (wr_fine)
				rc_fine <= reg_wdata;
		end
	end

	// regulator override and level registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			reg_ovr   <= rxo_pkg::RST_REG_OVR;
			reg_level <= rxo_pkg::RST_REG_LEVEL;
		end
		else
		begin
			if (wr_ovr)
				reg_ovr <= reg_wdata;
			if (wr_level)
				reg_level <= reg_wdata & 8'hF7;
		end
	end

	// adc tuning register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			adc_tuning_one <= rxo_pkg::RST_ADC_TUNE;
		else if (wr_adc)
			adc_tuning_one <= reg_wdata;
	end

	// effective calibration values
	// internal coarse when clear
	wire [6:0] coarse_eff = coarse_ovr ? rc_coarse[6:0] : cal_coarse_result;
	wire [6:0] fine_eff   = fine_ovr ? rc_fine[6:0] : cal_fine_result;
	wire [3:0] adc_eff    = adc_ovr ? adc_tuning_one[3:0] : cal_adc_tune;

	// global qualifier: high passes override both ways, low may only force on
	// override qualifier
	wire bias_eff = global_ovr ? reg_ovr[rxo_pkg::OVR_BIAS_BIT]
		: (reg_ovr[rxo_pkg::OVR_BIAS_BIT] | fsm_bias_en);
	wire xtal_eff = global_ovr ? reg_level[rxo_pkg::LVL_XTAL_BIT]
		: (reg_level[rxo_pkg::LVL_XTAL_BIT] | fsm_xtal_en);
	wire ts_eff   = global_ovr ? reg_level[rxo_pkg::LVL_TS_BIT]
		: (reg_level[rxo_pkg::LVL_TS_BIT] | fsm_ts_en);
	wire rc32_eff = global_ovr ? reg_level[rxo_pkg::LVL_RC32_BIT]
		: (reg_level[rxo_pkg::LVL_RC32_BIT] | fsm_rc32_en);

	wire buf_eff = buf_ovr ? xtal_ctrl[rxo_pkg::XTAL_BUFEN_BIT] : fsm_buf_en;

	wire dig_on_eff = !(reg_ovr[rxo_pkg::OVR_DPWD_BIT] && idle_mode);

	// control outputs registered so the blocks see glitch-free levels
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			xtal_buf_en          <= 1'b0;
			clk_hyst             <= 1'b0;
			double_bias          <= 1'b0;
			double_amplification <= 1'b1;
			rc_coarse_trim       <= 7'h00;
			rc_fine_trim         <= 7'h00;
			smart_por_en         <= 1'b1;
			bias_en              <= 1'b0;
			ldo_en               <= 5'h00;
			dig_domain_on        <= 1'b1;
			xtal_en              <= 1'b0;
			ts_en                <= 1'b0;
			rc32_en              <= 1'b0;
			dig_ldo_level        <= 3'h0;
			adc_reset            <= 1'b0;
			adc_refdac_en        <= 1'b0;
			adc_en               <= 1'b0;
			adc_tune             <= 4'h0;
		end
		else
		begin
			xtal_buf_en          <= buf_eff;
			clk_hyst             <= xtal_ctrl[rxo_pkg::XTAL_HYST_BIT];
			double_bias          <= xtal_ctrl[rxo_pkg::XTAL_BIAS_BIT];
			double_amplification <= xtal_ctrl[rxo_pkg::XTAL_AMP_BIT];
			rc_coarse_trim       <= coarse_eff;
			rc_fine_trim         <= fine_eff;
			smart_por_en         <= reg_ovr[rxo_pkg::OVR_SPOR_BIT];
			bias_en              <= bias_eff;
			ldo_en               <= reg_ovr[5:1];
			dig_domain_on        <= dig_on_eff;
			xtal_en              <= xtal_eff;
			ts_en                <= ts_eff;
			rc32_en              <= rc32_eff;
			dig_ldo_level        <= reg_level[2:0];
			adc_reset            <= adc_tuning_one[rxo_pkg::ADC_RST_BIT];
			adc_refdac_en        <= adc_tuning_one[rxo_pkg::ADC_REFDAC_BIT];
			adc_en               <= adc_tuning_one[rxo_pkg::ADC_EN_BIT];
			adc_tune             <= adc_eff;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		unique case (reg_addr)
			rxo_pkg::ADDR_COEF_ADDR:  reg_rdata = coef_addr;
			rxo_pkg::ADDR_COEF_VALUE: reg_rdata = {2'b00, coef_rd};
			rxo_pkg::ADDR_XTAL_CTRL:  reg_rdata = {power_state, xtal_ctrl};
			rxo_pkg::ADDR_RC_COARSE:  reg_rdata = {coarse_ovr, coarse_eff};
			rxo_pkg::ADDR_RC_FINE:    reg_rdata = {fine_ovr, fine_eff};
			rxo_pkg::ADDR_REG_OVR:    reg_rdata = reg_ovr;
			rxo_pkg::ADDR_REG_LEVEL:  reg_rdata = reg_level;
			rxo_pkg::ADDR_ADC_TUNE:   reg_rdata = adc_tuning_one;
			default:                  reg_rdata = 8'h00;
		endcase
	end
endmodule : rxo_regs
